// ### core/spf_acc_if.sv
`timescale 1ns/1ps
interface spf_acc_if;
  logic       req;   // one-cycle access request
  logic       wr;    // 1 write, 0 read
  logic [2:0] idx;   // flag number
  logic       wbit;  // value to write
  logic       done;  // one-cycle completion
  logic       rbit;  // flag value read

  modport main (output req, output wr, output idx, output wbit, input done, input rbit);
  modport seq  (input req, input wr, input idx, input wbit, output done, output rbit);
endinterface : spf_acc_if

// ### core/spf_access.sv
`timescale 1ns/1ps
`include "spf_defs.svh"
module spf_access
  import spf_pkg::*;
(
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rst_n,     // synchronised reset
  spf_acc_if.seq           acc,       // access request from controller
  input  wire logic        flag_rd,   // synchronised data bit 0
  output logic             sem_n,     // flag space select pin
  output logic             oe_n,      // output enable pin
  output logic             rw_n,      // read/write pin
  output logic [2:0]       idx,       // flag index pins
  output logic [15:0]      d_out,     // data pins out
  output logic             d_oe       // data pins drive enable
);

  localparam spf_seq_s_t SQ_RST = '{st: sq_idle, cnt: 3'h0, wr: 1'b0, rbit: `SPF_FREE,
                                    done: 1'b0, sem_n: `SPF_PIN_IDLE, oe_n: `SPF_PIN_IDLE,
                                    rw_n: `SPF_PIN_IDLE, idx: 3'h0, d_out: 16'h0000,
                                    d_oe: 1'b0};

  spf_seq_s_t s_r;
  spf_seq_s_t s_nxt;

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      sq_idle:
        if (acc.req)
        begin
          s_nxt.st    = sq_setup;
          s_nxt.cnt   = 3'(`SPF_SETUP_CYC - 1);
          s_nxt.sem_n = 1'b0;
          s_nxt.idx   = acc.idx;
          s_nxt.wr    = acc.wr;
          s_nxt.d_out = {16{acc.wbit}};
        end
      sq_setup:
        if (s_r.cnt == 3'h0)
        begin
          s_nxt.st  = sq_strobe;
          s_nxt.cnt = 3'(`SPF_STROBE_CYC - 1);
          if (s_r.wr)
          begin
            s_nxt.rw_n = 1'b0;
            s_nxt.d_oe = 1'b1;
          end
          else
            s_nxt.oe_n = 1'b0;
        end
        else
          s_nxt.cnt = s_r.cnt - 3'h1;
      sq_strobe:
        if (s_r.cnt == 3'h0)
        begin
          s_nxt.st   = sq_hold;
          s_nxt.rw_n = 1'b1;
          s_nxt.oe_n = 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - 3'h1;
      sq_hold:
      begin
        // synchroniser lag: this sample saw the pins mid-strobe
        if (!s_r.wr)
          s_nxt.rbit = flag_rd;
        s_nxt.d_oe  = 1'b0;
        s_nxt.sem_n = 1'b1;
        s_nxt.st    = sq_gap;
        s_nxt.cnt   = 3'(`SPF_GAP_CYC - 1);
      end
      sq_gap:
        if (s_r.cnt == 3'h0)
        begin
          s_nxt.st   = sq_idle;
          s_nxt.done = 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - 3'h1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= SQ_RST;
    else
      s_r <= s_nxt;
  end

  assign acc.done = s_r.done;
  assign acc.rbit = s_r.rbit;
  assign sem_n    = s_r.sem_n;
  assign oe_n     = s_r.oe_n;
  assign rw_n     = s_r.rw_n;
  assign idx      = s_r.idx;
  assign d_out    = s_r.d_out;
  assign d_oe     = s_r.d_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence read_pulse;
    !oe_n [*4] ##1 oe_n;
  endsequence

  a_read_strobe_len: assert property ($fell(oe_n) |-> read_pulse)
    else $error("read strobe length wrong");
  a_write_strobe_len: assert property ($fell(rw_n) |-> (!rw_n && d_oe) [*4] ##1 rw_n)
    else $error("write strobe length wrong");
  a_strobe_excl: assert property (!(!oe_n && !rw_n))
    else $error("read and write strobes together");
  a_poll_deselect: assert property ($rose(oe_n) |-> ##1 sem_n ##1 sem_n)
    else $error("select not dropped after read");
  a_strobe_selected: assert property ((!oe_n || !rw_n) |-> !sem_n)
    else $error("strobe outside flag space select");
  a_data_spread: assert property (d_oe |-> (d_out == 16'h0000 || d_out == 16'hFFFF))
    else $error("write data not a single bit value");

endmodule : spf_access

// ### core/spf_defs.svh
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SPF_N_FLAGS      8
`define SPF_IDX_W        3
`define SPF_DATA_W       16
`define SPF_LAST_IDX     3'h7

// ----------------------------------------------------------------
// written flag values (active low token) and idle pin level
// ----------------------------------------------------------------
`define SPF_TAKE         1'b0
`define SPF_FREE         1'b1
`define SPF_PIN_IDLE     1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPF_CLK_NS       20
`define SPF_SETUP_NS     20
`define SPF_STROBE_NS    80
`define SPF_GAP_NS       40
`define SPF_SETUP_CYC    ((`SPF_SETUP_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_STROBE_CYC   ((`SPF_STROBE_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_GAP_CYC      ((`SPF_GAP_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_CLAIM_TRIES  3'h4

`endif

// ### core/spf_pkg.sv
package spf_pkg;

  typedef enum logic [1:0] {op_init, op_claim, op_release, op_test} spf_op_t;

  typedef enum {sq_idle, sq_setup, sq_strobe, sq_hold, sq_gap} spf_seq_st_t;

  typedef enum {mn_boot, mn_boot_nx, mn_idle, mn_wait, mn_claim_rd, mn_claim_chk,
                mn_wd_done, mn_rel_done, mn_test_done} spf_main_st_t;

  typedef struct packed {
    spf_seq_st_t  st;
    logic [2:0]   cnt;
    logic         wr;
    logic         rbit;
    logic         done;
    logic         sem_n;
    logic         oe_n;
    logic         rw_n;
    logic [2:0]   idx;
    logic [15:0]  d_out;
    logic         d_oe;
  } spf_seq_s_t;

  typedef struct packed {
    spf_main_st_t st;
    spf_main_st_t after;
    logic [2:0]   idx;
    logic [2:0]   tries;
    logic         from_cmd;
    logic         req;
    logic         wr;
    logic         wbit;
    logic [7:0]   owned;
    logic         rsp_valid;
    logic         rsp_owned;
    logic         rsp_flag;
    logic         s1;
    logic         s2;
  } spf_main_s_t;

endpackage : spf_pkg

// ### core/spf_sem_host.sv
// Function
// - write zero requests, write one releases
// - select flag space, then plain SRAM strobes
// - drop select between repeated reads
// - claim by write, then read back
// - failed claim: poll, then withdraw with one
// - memory select high during flag access
// - write one to every flag at start
`timescale 1ns/1ps
`include "spf_defs.svh"
module spf_sem_host
  import spf_pkg::*;
(
  input  wire logic         clk_sys,              // system clock
  input  wire logic         nrst,                 // async reset, active low
  input  wire logic         cmd_valid,            // command request
  output logic              cmd_ready,            // controller idle
  input  wire spf_op_t      cmd_op,               // command code
  input  wire logic [2:0]   cmd_idx,              // flag number
  output logic              rsp_valid,            // one-cycle completion
  output logic              rsp_owned,            // claim granted
  output logic              rsp_flag,             // flag value read
  output logic [7:0]        owned_mask,           // flags held by this side
  output logic              flag_space_select_n,  // flag space select pin
  output logic              mem_select_n,         // memory array select pin
  output logic              oe_n,                 // output enable pin
  output logic              rw_n,                 // read/write pin
  output logic [2:0]        flag_index,           // flag index pins
  output logic [15:0]       data_out,             // data pins out
  output logic              data_oe,              // data pins drive enable
  input  wire logic [15:0]  data_in               // data pins in
);

  localparam spf_main_s_t MN_RST = '{st: mn_boot, after: mn_idle, idx: 3'h0,
                                     tries: 3'h0, from_cmd: 1'b0, req: 1'b0, wr: 1'b0,
                                     wbit: `SPF_FREE, owned: 8'h00, rsp_valid: 1'b0,
                                     rsp_owned: 1'b0, rsp_flag: `SPF_FREE,
                                     s1: `SPF_FREE, s2: `SPF_FREE};

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  spf_main_s_t s_r;
  spf_main_s_t s_nxt;
  spf_acc_if   acc ();

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.req       = 1'b0;
    s_nxt.rsp_valid = 1'b0;
    // bit 0 only; the device spreads the flag over every bit
    s_nxt.s1        = data_in[0];
    s_nxt.s2        = s_r.s1;
    unique case (s_r.st)
      mn_boot:
      begin
        s_nxt.req   = 1'b1;
        s_nxt.wr    = 1'b1;
        s_nxt.wbit  = `SPF_FREE;
        s_nxt.after = mn_boot_nx;
        s_nxt.st    = mn_wait;
      end
      mn_boot_nx:
        if (s_r.idx == `SPF_LAST_IDX)
        begin
          s_nxt.owned     = 8'h00;
          s_nxt.rsp_valid = s_r.from_cmd;
          s_nxt.rsp_owned = 1'b0;
          s_nxt.st        = mn_idle;
        end
        else
        begin
          s_nxt.idx = s_r.idx + 3'h1;
          s_nxt.st  = mn_boot;
        end
      mn_idle:
        if (cmd_valid)
        begin
          s_nxt.idx      = cmd_idx;
          s_nxt.from_cmd = 1'b1;
          s_nxt.tries    = `SPF_CLAIM_TRIES;
          s_nxt.st       = mn_wait;
          s_nxt.req      = 1'b1;
          unique case (cmd_op)
            op_init:
            begin
              s_nxt.idx = 3'h0;
              s_nxt.req = 1'b0;
              s_nxt.st  = mn_boot;
            end
            op_claim:
            begin
              s_nxt.wr    = 1'b1;
              s_nxt.wbit  = `SPF_TAKE;
              s_nxt.after = mn_claim_rd;
            end
            op_release:
            begin
              s_nxt.wr    = 1'b1;
              s_nxt.wbit  = `SPF_FREE;
              s_nxt.after = mn_rel_done;
            end
            op_test:
            begin
              s_nxt.wr    = 1'b0;
              s_nxt.after = mn_test_done;
            end
          endcase
        end
      mn_wait:
        if (acc.done)
          s_nxt.st = s_r.after;
      mn_claim_rd:
      begin
        s_nxt.req   = 1'b1;
        s_nxt.wr    = 1'b0;
        s_nxt.after = mn_claim_chk;
        s_nxt.st    = mn_wait;
      end
      mn_claim_chk:
        if (acc.rbit == `SPF_TAKE)
        begin
          s_nxt.owned[s_r.idx] = 1'b1;
          s_nxt.rsp_valid      = 1'b1;
          s_nxt.rsp_owned      = 1'b1;
          s_nxt.rsp_flag       = acc.rbit;
          s_nxt.st             = mn_idle;
        end
        else if (s_r.tries != 3'h0)
        begin
          // keep polling; the pending request may be handed the token
          s_nxt.tries = s_r.tries - 3'h1;
          s_nxt.req   = 1'b1;
          s_nxt.wr    = 1'b0;
          s_nxt.after = mn_claim_chk;
          s_nxt.st    = mn_wait;
        end
        else
        begin
          // withdraw, or a stale request would lock the other side out
          s_nxt.req   = 1'b1;
          s_nxt.wr    = 1'b1;
          s_nxt.wbit  = `SPF_FREE;
          s_nxt.after = mn_wd_done;
          s_nxt.st    = mn_wait;
        end
      mn_wd_done:
      begin
        s_nxt.rsp_valid = 1'b1;
        s_nxt.rsp_owned = 1'b0;
        s_nxt.rsp_flag  = `SPF_FREE;
        s_nxt.st        = mn_idle;
      end
      mn_rel_done:
      begin
        s_nxt.owned[s_r.idx] = 1'b0;
        s_nxt.rsp_valid      = 1'b1;
        s_nxt.rsp_owned      = 1'b0;
        s_nxt.rsp_flag       = `SPF_FREE;
        s_nxt.st             = mn_idle;
      end
      mn_test_done:
      begin
        s_nxt.rsp_valid = 1'b1;
        s_nxt.rsp_owned = s_r.owned[s_r.idx];
        s_nxt.rsp_flag  = acc.rbit;
        s_nxt.st        = mn_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= MN_RST;
    else
      s_r <= s_nxt;
  end

  assign acc.req      = s_r.req;
  assign acc.wr       = s_r.wr;
  assign acc.idx      = s_r.idx;
  assign acc.wbit     = s_r.wbit;
  assign cmd_ready    = (s_r.st == mn_idle);
  assign rsp_valid    = s_r.rsp_valid;
  assign rsp_owned    = s_r.rsp_owned;
  assign rsp_flag     = s_r.rsp_flag;
  assign owned_mask   = s_r.owned;
  assign mem_select_n = `SPF_PIN_IDLE;

  // ----------------------------------------------------------------
  // pin timing
  // ----------------------------------------------------------------
  spf_access u_access (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .acc     (acc),
    .flag_rd (s_r.s2),
    .sem_n   (flag_space_select_n),
    .oe_n    (oe_n),
    .rw_n    (rw_n),
    .idx     (flag_index),
    .d_out   (data_out),
    .d_oe    (data_oe)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence take_write;
    acc.req && acc.wr && (acc.wbit == `SPF_TAKE);
  endsequence

  sequence check_read;
    acc.req && !acc.wr;
  endsequence

  a_claim_readback: assert property (take_write |-> ##11 check_read)
    else $error("claim write not followed by readback");
  a_fail_withdraw: assert property (
    (s_r.st == mn_claim_chk && acc.rbit && s_r.tries == 3'h0)
    |-> ##1 (acc.req && acc.wr && acc.wbit))
    else $error("failed claim not withdrawn");
  a_boot_frees: assert property ((s_r.st == mn_boot) |->
                                 ##1 (acc.req && acc.wr && acc.wbit))
    else $error("start-up write is not a release");
  a_mem_deselect: assert property (!flag_space_select_n |-> mem_select_n)
    else $error("memory selected during flag access");
  a_release_clears: assert property ((s_r.st == mn_rel_done) |=>
                                     (rsp_valid && !owned_mask[s_r.idx]))
    else $error("release left ownership set");

endmodule : spf_sem_host

// ### dv/spf_dev_model.sv
`timescale 1ns/1ps
module spf_dev_model
(
  input  wire logic        l_sel_n,  // left flag space select
  input  wire logic        l_oe_n,   // left output enable
  input  wire logic        l_rw_n,   // left read/write
  input  wire logic [2:0]  l_idx,    // left flag index
  input  wire logic [15:0] l_d,      // left data pins in
  output logic      [15:0] l_q,      // left data pins out
  input  wire logic        r_sel_n,  // right flag space select
  input  wire logic        r_oe_n,   // right output enable
  input  wire logic        r_rw_n,   // right read/write
  input  wire logic [2:0]  r_idx,    // right flag index
  input  wire logic [15:0] r_d,      // right data pins in
  output logic      [15:0] r_q       // right data pins out
);
  // ----------------------------------------------------------------
  // latches: request 0 = asking, own 1 = side holds token
  // ----------------------------------------------------------------
  logic [7:0] req_l;
  logic [7:0] req_r;
  logic [7:0] own_l;
  logic [7:0] own_r;

  // no power-up init: left starts with stale requests set
  initial
  begin
    req_l = 8'h00;
    req_r = 8'hFF;
    own_l = 8'hFF;
    own_r = 8'h00;
    l_q   = 16'hA5A5;
    r_q   = 16'h5A5A;
  end

  // called after every write, so the earlier writer is settled first
  task automatic settle(input logic [2:0] i);
    if (!own_l[i] && !own_r[i])
    begin
      own_l[i] = !req_l[i];
      own_r[i] = req_l[i] && !req_r[i];
    end
    else if (own_l[i] && req_l[i])
    begin
      own_l[i] = 1'b0;
      own_r[i] = !req_r[i];
    end
    else if (own_r[i] && req_r[i])
    begin
      own_r[i] = 1'b0;
      own_l[i] = !req_l[i];
    end
  endtask : settle

  // ----------------------------------------------------------------
  // writes take bit 0 at the end of the strobe
  // ----------------------------------------------------------------
  always @(posedge l_rw_n)
    if (!l_sel_n)
    begin
      req_l[l_idx] = l_d[0];
      settle(l_idx);
    end
  always @(posedge r_rw_n)
    if (!r_sel_n)
    begin
      req_r[r_idx] = r_d[0];
      settle(r_idx);
    end

  // ----------------------------------------------------------------
  // reads latched at select and enable; released bus shows inverse
  // ----------------------------------------------------------------
  always @(negedge (l_sel_n | l_oe_n))
    l_q = {16{!own_l[l_idx]}};
  always @(posedge (l_sel_n | l_oe_n))
    l_q = ~l_q;
  always @(negedge (r_sel_n | r_oe_n))
    r_q = {16{!own_r[r_idx]}};
  always @(posedge (r_sel_n | r_oe_n))
    r_q = ~r_q;
endmodule : spf_dev_model

// ### dv/test_spf_sem_host.sv
`timescale 1ns/1ps
module test_spf_sem_host
  import spf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  spf_op_t cmd_op = op_init;
  logic [2:0] cmd_idx = 3'h0;
  logic cmd_ready, rsp_valid, rsp_owned, rsp_flag, sel_n, mem_n, oe_n, rw_n, d_oe;
  logic [7:0] owned_mask;
  logic [2:0] f_idx;
  logic [15:0] d_out, l_q, r_q, q;
  logic r_sel_n = 1'b1;
  logic r_oe_n = 1'b1;
  logic r_rw_n = 1'b1;
  logic [2:0] r_idx = 3'h0;
  logic [15:0] r_d = 16'hFFFF;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  // data pin level from both drivers
  wire [15:0] l_bus = d_oe ? d_out : l_q;

  always #10 clk_sys = ~clk_sys;

  spf_sem_host u_spf_sem_host (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_idx(cmd_idx), .rsp_valid(rsp_valid),
    .rsp_owned(rsp_owned), .rsp_flag(rsp_flag), .owned_mask(owned_mask),
    .flag_space_select_n(sel_n), .mem_select_n(mem_n), .oe_n(oe_n), .rw_n(rw_n),
    .flag_index(f_idx), .data_out(d_out), .data_oe(d_oe), .data_in(l_bus));
  spf_dev_model u_spf_dev_model (.l_sel_n(sel_n), .l_oe_n(oe_n), .l_rw_n(rw_n),
    .l_idx(f_idx), .l_d(l_bus), .l_q(l_q), .r_sel_n(r_sel_n), .r_oe_n(r_oe_n),
    .r_rw_n(r_rw_n), .r_idx(r_idx), .r_d(r_d), .r_q(r_q));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic host_cmd(input spf_op_t op, input logic [2:0] i);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_idx = i;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
  endtask : host_cmd

  task automatic r_write(input logic [2:0] i, input logic b);
    @(negedge clk_sys);
    r_sel_n = 1'b0;
    r_idx = i;
    r_d = {16{b}};
    @(negedge clk_sys);
    r_rw_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    r_rw_n = 1'b1;
    @(negedge clk_sys);
    r_sel_n = 1'b1;
  endtask : r_write

  task automatic r_read(input logic [2:0] i, output logic [15:0] v);
    @(negedge clk_sys);
    r_sel_n = 1'b0;
    r_idx = i;
    @(negedge clk_sys);
    r_oe_n = 1'b0;
    @(negedge clk_sys);
    v = r_q;
    r_oe_n = 1'b1;
    @(negedge clk_sys);
    r_sel_n = 1'b1;
  endtask : r_read

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    for (int i = 0; i < 8; i++)
      r_write(i[2:0], 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      host_cmd(op_test, i[2:0]);
      chk("test flag", {15'h0, rsp_flag}, 16'h0001);
      r_read(i[2:0], q);
      chk("right flag", q, 16'hFFFF);
    end
    chk("mem sel", {15'h0, mem_n}, 16'h0001);
    chk("mask", {8'h0, owned_mask}, 16'h0000);
  endtask : t_boot

  task automatic t_pass();
    host_cmd(op_claim, 3'h5);
    chk("claim owned", {15'h0, rsp_owned}, 16'h0001);
    chk("claim flag", {15'h0, rsp_flag}, 16'h0000);
    chk("mask", {8'h0, owned_mask}, 16'h0020);
    r_read(3'h5, q);
    chk("right flag", q, 16'hFFFF);
    r_write(3'h5, 1'b0);
    r_read(3'h5, q);
    chk("right pend", q, 16'hFFFF);
    host_cmd(op_test, 3'h5);
    chk("still held", {15'h0, rsp_flag}, 16'h0000);
    host_cmd(op_release, 3'h5);
    chk("mask", {8'h0, owned_mask}, 16'h0000);
    r_read(3'h5, q);
    chk("xfer right", q, 16'h0000);
    host_cmd(op_test, 3'h5);
    chk("xfer left", {15'h0, rsp_flag}, 16'h0001);
    host_cmd(op_claim, 3'h5);
    chk("fail owned", {15'h0, rsp_owned}, 16'h0000);
    chk("fail flag", {15'h0, rsp_flag}, 16'h0001);
    r_write(3'h5, 1'b1);
    r_read(3'h5, q);
    chk("withdrawn", q, 16'hFFFF);
    host_cmd(op_test, 3'h5);
    chk("free left", {15'h0, rsp_flag}, 16'h0001);
  endtask : t_pass

  task automatic t_latch();
    // right read opens while it still reads one; the hand-over must not reach it
    host_cmd(op_claim, 3'h3);
    chk("latch claim", {15'h0, rsp_owned}, 16'h0001);
    r_write(3'h3, 1'b0);
    @(negedge clk_sys);
    r_sel_n = 1'b0;
    r_idx = 3'h3;
    r_oe_n = 1'b0;
    host_cmd(op_release, 3'h3);
    chk("held read", r_q, 16'hFFFF);
    r_oe_n = 1'b1;
    @(negedge clk_sys);
    r_sel_n = 1'b1;
    r_read(3'h3, q);
    chk("reread", q, 16'h0000);
    r_write(3'h3, 1'b1);
  endtask : t_latch

  task automatic t_tie();
    // right write lands before the host write strobe ends
    fork
      r_write(3'h2, 1'b0);
      host_cmd(op_claim, 3'h2);
    join
    chk("tie host", {15'h0, rsp_owned}, 16'h0000);
    r_read(3'h2, q);
    chk("tie right", q, 16'h0000);
    r_write(3'h2, 1'b1);
    host_cmd(op_claim, 3'h1);
    host_cmd(op_init, 3'h0);
    chk("init mask", {8'h0, owned_mask}, 16'h0000);
    r_read(3'h1, q);
    chk("init free", q, 16'hFFFF);
  endtask : t_tie

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    t_boot();
    t_pass();
    t_latch();
    t_tie();
    complete_run();
  end
endmodule : test_spf_sem_host
